// >>> prpd_regs.svh
// Constants for the port/register pointer decode block.
// Assumes the serial front end presents whole bytes with strobes.
`ifndef PRPD_REGS_SVH
`define PRPD_REGS_SVH
`define PRPD_PTR_RESET    8'h00
`define PRPD_PTR_MASK     8'h7b
`define PRPD_SEL_MSB      6
`define PRPD_SEL_LSB      3
`define PRPD_PORT_MSB     1
`define PRPD_PORT_LSB     0
`define PRPD_ACK_CYCLES   4'h1
`endif

// >>> prpd_pkg.sv
// Types for the port/register pointer decode block.
// Assumes no surroundings beyond the including files.
package prpd_pkg;
  typedef enum logic [3:0] {
    PRPD_COMMON_RD  = 4'h0,
    PRPD_COMMON_CTL = 4'h1,
    PRPD_PCTL1      = 4'h2,
    PRPD_PCTL2      = 4'h3,
    PRPD_PSTAT1     = 4'h4,
    PRPD_PSTAT2     = 4'h5,
    PRPD_RES_LO     = 4'h6,
    PRPD_RES_HI     = 4'h7,
    PRPD_VOLT_LO    = 4'h8,
    PRPD_VOLT_HI    = 4'h9,
    PRPD_CUR_LO     = 4'ha,
    PRPD_CUR_HI     = 4'hb,
    PRPD_TEMP_LO    = 4'hc,
    PRPD_TEMP_HI    = 4'hd,
    PRPD_UNUSED     = 4'he,
    PRPD_TEST       = 4'hf
  } prpd_sel_t;
  typedef enum logic [1:0] {
    PRPD_ST_IDLE = 2'b01,
    PRPD_ST_ACK  = 2'b10
  } prpd_state_t;
endpackage

// >>> prpd_decode.sv
// Pointer byte register and target decode for a quad-port manager.
// Assumes ptr_valid pulses once on the falling serial clock after bit eight.
// Assumes wr_valid marks a data byte aimed at the currently selected target.
`timescale 1ns/1ps
`include "prpd_regs.svh"
module prpd_decode (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       ptr_valid,
  input  wire logic [7:0] ptr_byte,
  input  wire logic       wr_valid,
  output logic [7:0]      ptr_read,
  output logic [3:0]      reg_select,
  output logic [1:0]      port_select,
  output logic            ack_low,
  output logic            sel_read_reg,
  output logic            sel_write_reg,
  output logic            sel_unused,
  output logic            sel_common,
  output logic            sel_adc,
  output logic [3:0]      port_onehot,
  output logic [3:0]      wr_port_en
);
  // Stored pointer, acknowledge state and a strobe age used by the checks
  logic [7:0]            ptr;
  logic [7:0]            next_ptr;
  prpd_pkg::prpd_state_t state;
  prpd_pkg::prpd_state_t next_state;
  logic [3:0]            since_strobe;
  logic [3:0]            next_since_strobe;

  // Keep only the meaningful bits so the spare ones always read zero
  always_comb begin
    next_ptr = ptr;
    if (ptr_valid) begin
      next_ptr = ptr_byte & `PRPD_PTR_MASK;
    end
  end

  // Pointer register; a strobe during reset is dropped on purpose
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ptr <= `PRPD_PTR_RESET;
    end else begin
      ptr <= next_ptr;
    end
  end

  // Acknowledge sequencer: one cycle per accepted pointer byte
  always_comb begin
    next_state = state;
    case (state)
      prpd_pkg::PRPD_ST_IDLE: begin
        if (ptr_valid) begin
          next_state = prpd_pkg::PRPD_ST_ACK;
        end
      end
      prpd_pkg::PRPD_ST_ACK: begin
        // A strobe right behind the last one keeps the line low one more cycle
        if (!ptr_valid) begin
          next_state = prpd_pkg::PRPD_ST_IDLE;
        end
      end
      default: begin
        // An illegal code falls back to idle rather than hanging the acknowledge
        next_state = prpd_pkg::PRPD_ST_IDLE;
      end
    endcase
  end

  // Acknowledge state register
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state <= prpd_pkg::PRPD_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Cycles since the last accepted strobe, saturating; only the checks read it
  always_comb begin
    next_since_strobe = since_strobe;
    if (ptr_valid) begin
      next_since_strobe = 4'h0;
    end else if (since_strobe != 4'hf) begin
      next_since_strobe = since_strobe + 4'h1;
    end
  end

  // Starts saturated so no acknowledge is expected straight out of reset
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      since_strobe <= 4'hf;
    end else begin
      since_strobe <= next_since_strobe;
    end
  end

  // Field views of the stored pointer
  assign ptr_read    = ptr;
  assign reg_select  = ptr[`PRPD_SEL_MSB:`PRPD_SEL_LSB];
  assign port_select = ptr[`PRPD_PORT_MSB:`PRPD_PORT_LSB];
  assign ack_low     = (state == prpd_pkg::PRPD_ST_ACK);

  // Target class decode; read and write targets never overlap
  always_comb begin
    sel_read_reg  = 1'b0;
    sel_write_reg = 1'b0;
    sel_unused    = 1'b0;
    sel_common    = 1'b0;
    sel_adc       = 1'b0;
    if (reg_select == prpd_pkg::PRPD_COMMON_RD) begin
      sel_read_reg = 1'b1;
      sel_common   = 1'b1;
    end else if (reg_select == prpd_pkg::PRPD_COMMON_CTL) begin
      sel_write_reg = 1'b1;
      sel_common    = 1'b1;
    end else if (reg_select == prpd_pkg::PRPD_PCTL1 ||
                 reg_select == prpd_pkg::PRPD_PCTL2) begin
      // Per-port targets: only the addressed port is written
      sel_write_reg = 1'b1;
    end else if (reg_select == prpd_pkg::PRPD_PSTAT1 ||
                 reg_select == prpd_pkg::PRPD_PSTAT2) begin
      sel_read_reg = 1'b1;
    end else if (reg_select == prpd_pkg::PRPD_UNUSED) begin
      // Nothing stands behind code fourteen, so it is neither read nor written
      sel_unused = 1'b1;
    end else if (reg_select == prpd_pkg::PRPD_TEST) begin
      sel_write_reg = 1'b1;
      sel_common    = 1'b1;
    end else begin
      // What is left is six to thirteen, the converter result bytes
      sel_read_reg = 1'b1;
      sel_adc      = 1'b1;
    end
  end

  // One enable per port; a common write register (codes one and fifteen) reaches every port at once
  for (genvar p = 0; p < 4; p++) begin : g_port
    assign port_onehot[p] = (port_select == 2'(p));
    assign wr_port_en[p]  = wr_valid & sel_write_reg & (sel_common | port_onehot[p]);
  end

  // Pointer storage and acknowledge checks
  ack_one_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    ptr_valid |=> ack_low ##1 (!ack_low || $past(ptr_valid)))
    else $error("ack not one cycle");
  ack_span_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    ack_low == (since_strobe < `PRPD_ACK_CYCLES))
    else $error("ack length wrong");
  ack_cause_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    ack_low |-> $past(ptr_valid))
    else $error("ack without pointer");
  ptr_load_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    ptr_valid |=> ptr_read == ($past(ptr_byte) & `PRPD_PTR_MASK))
    else $error("pointer not loaded");
  ptr_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !ptr_valid |=> $stable(ptr_read))
    else $error("pointer changed without strobe");
  ptr_fields_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    ptr_valid |=> reg_select == $past(ptr_byte[`PRPD_SEL_MSB:`PRPD_SEL_LSB]) &&
                  port_select == $past(ptr_byte[`PRPD_PORT_MSB:`PRPD_PORT_LSB]))
    else $error("pointer fields not loaded");
  spare_zero_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    ptr_read[7] == 1'b0 && ptr_read[2] == 1'b0)
    else $error("spare bits not zero");
  reset_clear_a: assert property (@(posedge core_clk)
    !reset_n |=> ptr_read == `PRPD_PTR_RESET && !ack_low)
    else $error("reset did not clear pointer");

  // Register select decode checks
  common_rd_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    reg_select == 4'h0 |-> sel_read_reg && sel_common && !sel_write_reg)
    else $error("code zero decode");
  common_ctl_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    reg_select == 4'h1 |-> sel_write_reg && sel_common)
    else $error("code one decode");
  port_ctl_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (reg_select == 4'h2 || reg_select == 4'h3) |-> sel_write_reg && !sel_common)
    else $error("port control decode");
  port_stat_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (reg_select == 4'h4 || reg_select == 4'h5) |-> sel_read_reg && !sel_adc)
    else $error("port status decode");
  rd_no_en_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    sel_read_reg |-> wr_port_en == 4'h0)
    else $error("read target written");
  adc_range_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    sel_adc == (reg_select >= 4'h6 && reg_select <= 4'hd))
    else $error("adc range decode");
  adc_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    sel_adc |-> sel_read_reg && !sel_common && !sel_write_reg)
    else $error("adc target not a port read");
  test_unused_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    sel_unused == (reg_select == 4'he) && (reg_select != 4'hf || sel_write_reg))
    else $error("code fourteen or fifteen decode");
  target_one_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    $onehot({sel_read_reg, sel_write_reg, sel_unused}))
    else $error("target class not unique");
  unused_quiet_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    sel_unused |-> !sel_common && !sel_adc && wr_port_en == 4'h0)
    else $error("code fourteen reaches a port");

  // Port decode and write fan-out; a common write target must reach all four ports
  port_hot_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    port_onehot == (4'h1 << port_select))
    else $error("port decode");
  wr_spread_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_valid && sel_write_reg |-> wr_port_en == (sel_common ? 4'hf : port_onehot))
    else $error("write spread");
  en_gate_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !(wr_valid && sel_write_reg) |-> wr_port_en == 4'h0)
    else $error("write enable without write");

  // Covers for the main scenarios
  load_c: cover property (@(posedge core_clk) disable iff (!reset_n)
    ptr_valid ##1 ack_low);
  b2b_c: cover property (@(posedge core_clk) disable iff (!reset_n)
    ptr_valid ##1 ptr_valid ##1 ack_low);
  common_wr_c: cover property (@(posedge core_clk) disable iff (!reset_n)
    wr_valid && wr_port_en == 4'hf);
  port4_wr_c: cover property (@(posedge core_clk) disable iff (!reset_n)
    wr_valid && wr_port_en == 4'h8);
  adc_c: cover property (@(posedge core_clk) disable iff (!reset_n)
    sel_adc);
endmodule

// >>> prpd_host.sv
// Host model: writes pointer bytes and data strobes into the decode.
// Assumes tasks are called at a falling core_clk edge.
`timescale 1ns/1ps
module prpd_host (
  input  wire logic core_clk,
  output logic      ptr_valid,
  output logic [7:0] ptr_byte,
  output logic      wr_valid
);
  initial begin
    ptr_valid = 1'b0;
    ptr_byte  = 8'h00;
    wr_valid  = 1'b0;
  end
  // Pointer written first; rel=0 keeps the strobe up for back to back
  task automatic send(input logic [7:0] b, input logic rel);
    ptr_valid = 1'b1;
    ptr_byte  = b;
    @(negedge core_clk);
    // Stale byte is inverted so nothing leans on it
    if (rel) begin
      ptr_valid = 1'b0;
      ptr_byte  = ~b;
    end
  endtask
  // Data strobe level, held by the caller for one cycle
  task automatic wr(input logic on);
    wr_valid = on;
  endtask
endmodule

// >>> tb.sv
// Self-checking bench for the pointer decode.
// Assumes prpd_host drives all data inputs on the falling edge.
`timescale 1ns/1ps
module tb;
  logic       core_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       ptr_valid, wr_valid, ack_low, s_rd, s_wr, s_un, s_com, s_adc;
  logic [7:0] ptr_byte, ptr_read;
  logic [3:0] reg_select, port_onehot, wr_port_en;
  logic [1:0] port_select;
  int         miscompares = 0;
  int         cmp_count = 0;
  always #2 core_clk = ~core_clk;
  prpd_host host (.core_clk(core_clk), .ptr_valid(ptr_valid), .ptr_byte(ptr_byte),
    .wr_valid(wr_valid));
  prpd_decode dut (.core_clk(core_clk), .reset_n(reset_n), .ptr_valid(ptr_valid),
    .ptr_byte(ptr_byte), .wr_valid(wr_valid), .ptr_read(ptr_read),
    .reg_select(reg_select), .port_select(port_select), .ack_low(ack_low),
    .sel_read_reg(s_rd), .sel_write_reg(s_wr), .sel_unused(s_un), .sel_common(s_com),
    .sel_adc(s_adc), .port_onehot(port_onehot), .wr_port_en(wr_port_en));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask
  // Expected flags {read, write, unused, common, adc} per select code
  function automatic logic [7:0] flags(input logic [3:0] c);
    return {3'h0, c == 4'h0 || (c >= 4'h4 && c <= 4'hd), c inside {4'h1, 4'h2, 4'h3, 4'hf},
      c == 4'he, c inside {4'h0, 4'h1, 4'hf}, c >= 4'h6 && c <= 4'hd};
  endfunction
  // Reset used at start and again at the end of the run
  task automatic t_reset;
    reset_n = 1'b0;
    repeat (2) @(negedge core_clk);
    check(ptr_read, 8'h00, "ptr reset");
    check({2'h0, ack_low, wr_port_en, port_onehot[0]}, 8'h01, "ack/port reset");
    check({6'h0, s_rd, s_com}, 8'h03, "code zero at reset");
    reset_n = 1'b1;
    @(negedge core_clk);
    check({7'h0, ack_low}, 8'h00, "no ack after release");
    check(ptr_read, 8'h00, "ptr after release");
  endtask
  // Every code, spare bits set, port stepping with the code
  task automatic t_codes;
    logic [7:0] b;
    logic [7:0] f;
    logic [3:0] oh;
    for (int i = 0; i < 16; i++) begin
      b = {1'b1, 4'(i), 1'b1, 2'(i)};
      oh = 4'h1 << i[1:0];
      f = flags(4'(i));
      host.send(b, 1'b1);
      check(ptr_read, b & 8'h7b, "spare bits");
      check({reg_select, port_onehot}, {4'(i), oh}, "fields");
      check({6'h0, port_select}, {6'h0, i[1:0]}, "port field");
      check({7'h0, ack_low}, 8'h01, "ack high");
      check({3'h0, s_rd, s_wr, s_un, s_com, s_adc}, f, "decode");
      host.wr(1'b1);
      #1;
      check({4'h0, wr_port_en}, !f[3] ? 8'h00 : (f[1] ? 8'h0f : {4'h0, oh}), "wr en");
      @(negedge core_clk);
      host.wr(1'b0);
      check({7'h0, ack_low}, 8'h00, "ack one cycle");
    end
  endtask
  // Back to back pointers stretch the acknowledge to two cycles
  task automatic t_b2b;
    host.send(8'h9a, 1'b0);
    check(ptr_read, 8'h1a, "first ptr");
    host.send(8'hfc, 1'b1);
    check(ptr_read, 8'h78, "second ptr");
    check({7'h0, ack_low}, 8'h01, "ack held");
    @(negedge core_clk);
    check({7'h0, ack_low}, 8'h00, "ack drop");
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    t_reset();
    t_codes();
    t_b2b();
    t_reset();
    close_out();
  end
  // Whole run is under 100 cycles; this only cuts a hang
  initial begin
    #4000;
    miscompares++;
    close_out();
  end
endmodule
